// >>> design/freq_ctl_pkg.sv
package freq_ctl_pkg;
   // Frequency word: nine BCD digits, digit 0 is 1 kHz, digit 8 is 100 GHz
   localparam int NUM_DIGITS = 9;
   localparam int CYCLE_STEPS = 18;
   localparam int DIGIT_W = 4;
   localparam int FREQ_W = NUM_DIGITS * DIGIT_W;

   typedef logic [DIGIT_W-1:0] digit_t;

   typedef struct packed {
      digit_t [NUM_DIGITS-1:0] digit;
   } freq_s;

   typedef struct packed {
      logic band_bit_b;
      logic band_bit_a;
   } band_s;

   // BCD words in kHz; packed BCD compares like plain binary
   localparam logic [FREQ_W-1:0] PRESET_BCD = 36'h003000000;
   localparam logic [FREQ_W-1:0] LIMIT_LOW_BCD = 36'h002000000;
   localparam logic [FREQ_W-1:0] LIMIT_HIGH_BCD = 36'h018000000;
   localparam logic [FREQ_W-1:0] BAND_TWO_BCD = 36'h006200000;
   localparam logic [FREQ_W-1:0] BAND_THREE_BCD = 36'h012400000;

   // Clock figures
   localparam int CORE_CLK_HZ = 40_000_000;
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int GUARD_TIME_MS = 500;
   // Longest time, so rounded down
   localparam int GUARD_CYCLES_DEF = (CORE_CLK_HZ / 1000) * GUARD_TIME_MS;
   localparam int GUARD_CNT_W = 25;

   // Synchroniser slots for pin inputs
   localparam int SY_REF = 0;
   localparam int SY_KNOB = 1;
   localparam int SY_CCW = 2;
   localparam int SY_PRESET = 3;
   localparam int SY_FORCE = 4;
   localparam int SY_SUPPR = 5;
   localparam int SY_W = 6;

   typedef enum logic {
      ST_IDLE,
      ST_RUN
   } cyc_state_e;
endpackage

// >>> design/bcd_step_adder.sv
// One BCD digit of the serial plus-or-minus-one adder
module bcd_step_adder
   import freq_ctl_pkg::*;
(
   input wire freq_ctl_pkg::digit_t i_digit,
   input wire logic i_carry,
   input wire logic i_down,
   output freq_ctl_pkg::digit_t o_digit,
   output logic o_carry
);
   // Carry means +1 going up, borrow going down
   always_comb begin
      o_digit = i_digit;
      o_carry = 1'b0;
      if (i_carry && !i_down) begin
         if (i_digit >= 4'h9) begin
            o_digit = 4'h0;
            o_carry = 1'b1;
         end else begin
            o_digit = i_digit + 4'h1;
         end
      end else if (i_carry && i_down) begin
         if (i_digit == 4'h0) begin
            o_digit = 4'h9;
            o_carry = 1'b1;
         end else begin
            o_digit = i_digit - 4'h1;
         end
      end
   end
endmodule // bcd_step_adder

// >>> design/frequency_digit_register_control.sv
// Summary of operation
// - While the force strap is set, data cycles run back to back.
// - Cycle steps are paced by edges of the 10 MHz reference input.
// - The clock guard is high from power-up and drops in under a second.
// - While the suppress strap is set, out-of-limit knob changes stay.
// - Range error is low above 2 GHz and high below it.
// - A remote load is accepted even out of range; only a load below 2 GHz is flagged.
// - Knob direction output is low for clockwise, high for the other way.
// - Preset loads 3000.000 MHz and shows it on the display word.
// - At 1 kHz resolution knob steps move the 1 kHz digit up or down.
// - At resolutions 0 to 8 knob steps move the selected digit; above 8 no digit moves.
// - Band bits read 00 at 2 GHz, a at 10 GHz and b at 18 GHz.
// - A cycle is 18 steps; the first nine pass digits LSB first.
// - A decode error at cycle end starts more cycles until it clears.
// - A band remainder is rounded by one, the same way as the last knob or undo step.
// - After preset only the two gigahertz weight bits are set.
module frequency_digit_register_control
   import freq_ctl_pkg::*;
#(
   parameter int unsigned GUARD_CYCLES = freq_ctl_pkg::GUARD_CYCLES_DEF
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_ref_clk,
   input wire logic i_rotary_pulse_knob,
   input wire logic i_knob_ccw,
   input wire logic [3:0] i_resolution,
   input wire logic i_preset_key,
   input wire logic i_load,
   input wire freq_ctl_pkg::freq_s i_load_freq,
   input wire logic i_force_cycle_strap,
   input wire logic i_limit_suppress_strap,
   output freq_ctl_pkg::freq_s o_freq,
   output freq_ctl_pkg::band_s o_band,
   output logic o_range_error,
   output logic o_decode_error_n,
   output logic o_knob_direction,
   output logic o_power_up_clock_guard,
   output logic o_phase_two_tick_n,
   output logic o_phase_three_tick_n,
   output logic o_cycle_active
);
   import freq_ctl_pkg::*;

   // Parameters the counter cannot serve
   if (GUARD_CYCLES < 1 || GUARD_CYCLES >= (1 << GUARD_CNT_W)) begin : g_bad
      $error("GUARD_CYCLES out of range");
   end

   logic [SY_W-1:0] sy_a_r, sy_b_r, sy_c_r;
   logic ref_tick, knob_edge, preset_edge, force_s, suppr_s, ccw_s;
   logic guard_r, guard_nxt;
   logic [GUARD_CNT_W-1:0] gcnt_r, gcnt_nxt;
   cyc_state_e state_r, state_nxt;
   logic [4:0] step_r, step_nxt;
   logic op_r, op_nxt, dir_r, dir_nxt, carry_r, carry_nxt;
   logic [3:0] sel_r, sel_nxt;
   logic round_dir_r, round_dir_nxt, knob_flag_r, knob_flag_nxt;
   logic knob_pend_r, knob_pend_nxt, preset_pend_r, preset_pend_nxt;
   logic load_pend_r, load_pend_nxt;
   freq_s freq_r, freq_nxt, load_buf_r, load_buf_nxt;
   band_s band_r, band_nxt, band_now;
   logic rerr_r, rerr_nxt, derr_n_r, derr_n_nxt;
   logic tick2_n_r, tick2_n_nxt, tick3_n_r, tick3_n_nxt;
   logic below_low, above_high, rem, undo, end_evt, go;
   logic [3:0] idx;
   logic [6:0] dsum;
   digit_t add_out;
   logic add_cout, add_cin;

   // Two flip-flops on each of the six pin inputs; third stage for edge detection and the knob direction output
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         sy_a_r <= '0;
         sy_b_r <= '0;
         sy_c_r <= '0;
      end else if (i_ce) begin
         sy_a_r <= {i_limit_suppress_strap, i_force_cycle_strap,
                    i_preset_key, i_knob_ccw, i_rotary_pulse_knob, i_ref_clk};
         sy_b_r <= sy_a_r;
         sy_c_r <= sy_b_r;
      end
   end

   assign ref_tick = sy_b_r[SY_REF] & ~sy_c_r[SY_REF];
   assign knob_edge = sy_b_r[SY_KNOB] & ~sy_c_r[SY_KNOB];
   assign preset_edge = sy_b_r[SY_PRESET] & ~sy_c_r[SY_PRESET];
   assign ccw_s = sy_b_r[SY_CCW];
   assign force_s = sy_b_r[SY_FORCE];
   assign suppr_s = sy_b_r[SY_SUPPR];

   // Power-up guard: high out of reset, released after the count
   always_comb begin
      guard_nxt = guard_r;
      gcnt_nxt = gcnt_r;
      if (guard_r) begin
         if (gcnt_r == GUARD_CNT_W'(GUARD_CYCLES - 1)) begin
            guard_nxt = 1'b0;
         end else begin
            gcnt_nxt = gcnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         guard_r <= 1'b1;
         gcnt_r <= '0;
      end else if (i_ce) begin
         guard_r <= guard_nxt;
         gcnt_r <= gcnt_nxt;
      end
   end

   // Decoders look at the whole word; BCD order equals binary order
   always_comb begin
      dsum = '0;
      for (int k = 0; k < NUM_DIGITS; k++) begin
         dsum = dsum + 7'(freq_r.digit[k]);
      end
      below_low = freq_r < LIMIT_LOW_BCD;
      above_high = freq_r > LIMIT_HIGH_BCD;
      band_now.band_bit_a = (freq_r >= BAND_TWO_BCD) &&
                            (freq_r < BAND_THREE_BCD);
      band_now.band_bit_b = freq_r >= BAND_THREE_BCD;
      // Even/3-divisibility from LSB parity and digit sum
      rem = (band_now.band_bit_a && freq_r.digit[0][0]) ||
            (band_now.band_bit_b && (dsum % 7'd3) != 7'd0);
      undo = knob_flag_r && !suppr_s && (below_low || above_high);
   end

   // Serial adder sees one digit per step, LSB first
   assign idx = (step_r < 5'(NUM_DIGITS)) ? step_r[3:0] : 4'h0;
   assign add_cin = carry_r | (op_r && step_r[3:0] == sel_r &&
                    step_r < 5'(NUM_DIGITS));

   bcd_step_adder u_adder (
      .i_digit(freq_r.digit[idx]),
      .i_carry(add_cin),
      .i_down(dir_r),
      .o_digit(add_out),
      .o_carry(add_cout)
   );

   assign end_evt = !guard_r && state_r == ST_RUN && ref_tick &&
                    step_r == 5'(CYCLE_STEPS - 1);

   // Cycle sequencer and frequency register
   always_comb begin
      state_nxt = state_r;
      step_nxt = step_r;
      op_nxt = op_r;
      dir_nxt = dir_r;
      sel_nxt = sel_r;
      carry_nxt = carry_r;
      freq_nxt = freq_r;
      round_dir_nxt = round_dir_r;
      knob_flag_nxt = knob_flag_r;
      band_nxt = band_r;
      rerr_nxt = rerr_r;
      derr_n_nxt = derr_n_r;
      go = 1'b0;
      // Set wins over consume
      knob_pend_nxt = knob_pend_r | knob_edge;
      preset_pend_nxt = preset_pend_r | preset_edge;
      load_pend_nxt = load_pend_r | i_load;
      load_buf_nxt = i_load ? i_load_freq : load_buf_r;
      tick2_n_nxt = 1'b1;
      tick3_n_nxt = 1'b1;
      if (guard_r) begin
         // Nothing reaches the register while guarded
         knob_pend_nxt = 1'b0;
         preset_pend_nxt = 1'b0;
         load_pend_nxt = 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (preset_pend_r) begin
                  freq_nxt = PRESET_BCD;
                  preset_pend_nxt = preset_edge;
                  op_nxt = 1'b0;
                  knob_flag_nxt = 1'b0;
                  go = 1'b1;
               end else if (load_pend_r) begin
                  freq_nxt = load_buf_r;
                  load_pend_nxt = i_load;
                  op_nxt = 1'b0;
                  knob_flag_nxt = 1'b0;
                  go = 1'b1;
               end else if (knob_pend_r) begin
                  knob_pend_nxt = knob_edge;
                  op_nxt = 1'b1;
                  dir_nxt = ccw_s;
                  sel_nxt = i_resolution;
                  round_dir_nxt = ccw_s;
                  knob_flag_nxt = 1'b1;
                  go = 1'b1;
               end else if (force_s) begin
                  op_nxt = 1'b0;
                  go = 1'b1;
               end
            end
            ST_RUN: begin
               if (ref_tick) begin
                  tick2_n_nxt = step_r >= 5'(NUM_DIGITS);
                  tick3_n_nxt = step_r < 5'(NUM_DIGITS);
                  if (step_r < 5'(NUM_DIGITS)) begin
                     freq_nxt.digit[idx] = add_out;
                     carry_nxt = add_cout;
                  end
                  step_nxt = step_r + 5'd1;
                  if (end_evt) begin
                     band_nxt = band_now;
                     rerr_nxt = below_low;
                     derr_n_nxt = !(rem || undo);
                     state_nxt = ST_IDLE;
                     if (rem) begin
                        // Round at 1 kHz, same way as last step
                        op_nxt = 1'b1;
                        dir_nxt = round_dir_r;
                        sel_nxt = 4'h0;
                        go = 1'b1;
                     end else if (undo) begin
                        // Back out the knob step that left the limits
                        op_nxt = 1'b1;
                        dir_nxt = ~dir_r;
                        round_dir_nxt = ~dir_r;
                        knob_flag_nxt = 1'b0;
                        go = 1'b1;
                     end
                  end
               end
            end
            default: state_nxt = ST_IDLE;
         endcase
      end
      if (go) begin
         state_nxt = ST_RUN;
         step_nxt = '0;
         carry_nxt = 1'b0;
      end
   end

   // Reset stands in for a cold start with a flat battery
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         state_r <= ST_IDLE;
         step_r <= '0;
         op_r <= 1'b0;
         dir_r <= 1'b0;
         sel_r <= '0;
         carry_r <= 1'b0;
         freq_r <= PRESET_BCD;
         round_dir_r <= 1'b0;
         knob_flag_r <= 1'b0;
         knob_pend_r <= 1'b0;
         preset_pend_r <= 1'b0;
         load_pend_r <= 1'b0;
         load_buf_r <= '0;
         band_r <= '0;
         rerr_r <= 1'b0;
         derr_n_r <= 1'b1;
         tick2_n_r <= 1'b1;
         tick3_n_r <= 1'b1;
      end else if (i_ce) begin
         state_r <= state_nxt;
         step_r <= step_nxt;
         op_r <= op_nxt;
         dir_r <= dir_nxt;
         sel_r <= sel_nxt;
         carry_r <= carry_nxt;
         freq_r <= freq_nxt;
         round_dir_r <= round_dir_nxt;
         knob_flag_r <= knob_flag_nxt;
         knob_pend_r <= knob_pend_nxt;
         preset_pend_r <= preset_pend_nxt;
         load_pend_r <= load_pend_nxt;
         load_buf_r <= load_buf_nxt;
         band_r <= band_nxt;
         rerr_r <= rerr_nxt;
         derr_n_r <= derr_n_nxt;
         tick2_n_r <= tick2_n_nxt;
         tick3_n_r <= tick3_n_nxt;
      end
   end

   assign o_freq = freq_r;
   assign o_band = band_r;
   assign o_range_error = rerr_r;
   assign o_decode_error_n = derr_n_r;
   assign o_knob_direction = sy_c_r[SY_CCW];
   assign o_power_up_clock_guard = guard_r;
   assign o_phase_two_tick_n = tick2_n_r;
   assign o_phase_three_tick_n = tick3_n_r;
   assign o_cycle_active = state_r == ST_RUN;

   property p_guard_hold;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      guard_r |=> $stable(freq_r);
   endproperty
   a_guard_hold: assert property (p_guard_hold)
      else $error("register changed under clock guard");

   property p_guard_release;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && guard_r && gcnt_r == GUARD_CNT_W'(GUARD_CYCLES - 1)
      |=> !o_power_up_clock_guard;
   endproperty
   a_guard_release: assert property (p_guard_release)
      else $error("clock guard not released");

   property p_preset;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && !guard_r && state_r == ST_IDLE && preset_pend_r
      |=> o_freq == PRESET_BCD && o_cycle_active;
   endproperty
   a_preset: assert property (p_preset)
      else $error("preset did not load 3000 MHz");

   property p_range;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && end_evt |=> o_range_error == (o_freq < LIMIT_LOW_BCD);
   endproperty
   a_range: assert property (p_range)
      else $error("range error wrong at cycle end");

   property p_band;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && end_evt && freq_r == 36'h010000000
      |=> o_band.band_bit_a && !o_band.band_bit_b;
   endproperty
   a_band: assert property (p_band)
      else $error("band bits wrong at 10 GHz");

   property p_step_pace;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      o_cycle_active && $changed(step_r) && step_r != 5'd0
      |-> $past(ref_tick) && $past(i_ce);
   endproperty
   a_step_pace: assert property (p_step_pace)
      else $error("step moved without reference edge");

   // A running cycle must not end or skip before its last step
   property p_cycle_len;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && state_r == ST_RUN && ref_tick
         && step_r < 5'(CYCLE_STEPS - 1)
      |=> o_cycle_active && step_r == $past(step_r) + 5'd1;
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("cycle ended before its last step");

   property p_retry;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && end_evt && rem |=> o_cycle_active && op_r && sel_r == 4'h0
         && !o_decode_error_n;
   endproperty
   a_retry: assert property (p_retry)
      else $error("no rounding cycle after remainder");

   property p_force;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && !guard_r && state_r == ST_IDLE && force_s |=> o_cycle_active;
   endproperty
   a_force: assert property (p_force)
      else $error("forced cycling did not start a cycle");

   property p_knob_start;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      i_ce && !guard_r && state_r == ST_IDLE && !preset_pend_r
         && !load_pend_r && knob_pend_r
      |=> op_r && sel_r == $past(i_resolution) && dir_r == $past(ccw_s);
   endproperty
   a_knob_start: assert property (p_knob_start)
      else $error("knob step did not start a stepping cycle");
endmodule // frequency_digit_register_control

// >>> verification/panel_model.sv
// Front panel stand-in: reference oscillator, tuning knob and preset key
module panel_model (
   input wire logic i_core_clk,
   output logic o_ref_clk,
   output logic o_knob,
   output logic o_knob_ccw,
   output logic o_preset_key
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_r;

   initial begin
      div_r = 2'h0;
      o_ref_clk = 1'b0;
      o_knob = 1'b0;
      o_knob_ccw = 1'b0;
      o_preset_key = 1'b0;
   end

   // Oscillator never stops, so the 10 MHz reference runs free
   always @(posedge i_core_clk) begin
      div_r <= div_r + 2'h1;
      o_ref_clk <= div_r[1];
   end

   // One detent: direction settles before the pulse, held past its end
   task automatic turn(input logic ccw);
      @(posedge i_core_clk);
      o_knob_ccw <= ccw;
      repeat (3) @(posedge i_core_clk);
      o_knob <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_knob <= 1'b0;
   endtask

   // Key held long enough for the pin synchroniser to see it
   task automatic press_preset();
      @(posedge i_core_clk);
      o_preset_key <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_preset_key <= 1'b0;
   endtask
endmodule // panel_model

// >>> verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import freq_ctl_pkg::*;
   logic clk = 1'b0;
   logic ce = 1'b1;
   logic rst_b = 1'b0;
   logic [3:0] res = 4'h0;
   logic load = 1'b0;
   freq_s load_freq = '0;
   logic force_strap = 1'b0;
   logic suppr_strap = 1'b0;
   logic ref_clk, knob, knob_ccw, preset_key;
   freq_s freq;
   band_s band;
   logic range_err, dec_err_n, knob_dir, guard, two_n, three_n, active;
   int mismatches = 0;
   int n_checks = 0;
   int n_two, n_three, n_rise;
   logic err_seen;

   // 40 MHz core clock
   always #12.5 clk = ~clk;

   panel_model u_panel (.i_core_clk(clk), .o_ref_clk(ref_clk),
      .o_knob(knob), .o_knob_ccw(knob_ccw), .o_preset_key(preset_key));

   // Short guard time keeps the run brief
   frequency_digit_register_control #(.GUARD_CYCLES(8)) u_dut (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_ref_clk(ref_clk),
      .i_rotary_pulse_knob(knob), .i_knob_ccw(knob_ccw),
      .i_resolution(res), .i_preset_key(preset_key), .i_load(load),
      .i_load_freq(load_freq), .i_force_cycle_strap(force_strap),
      .i_limit_suppress_strap(suppr_strap), .o_freq(freq), .o_band(band),
      .o_range_error(range_err), .o_decode_error_n(dec_err_n),
      .o_knob_direction(knob_dir), .o_power_up_clock_guard(guard),
      .o_phase_two_tick_n(two_n), .o_phase_three_tick_n(three_n),
      .o_cycle_active(active));

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_freq(input freq_s got, input logic [35:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits for a cycle to start, then for eight quiet cycles; retries count
   task automatic wait_done();
      int n;
      int quiet;
      n = 0;
      quiet = 0;
      n_two = 0;
      n_three = 0;
      err_seen = 1'b0;
      while (active !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      // A cycle that never starts is a timeout too
      if (active !== 1'b1) begin
         mismatches++;
         complete_run();
      end
      while (quiet < 8 && n < 6000) begin
         @(negedge clk);
         n++;
         if (two_n === 1'b0) n_two++;
         if (three_n === 1'b0) n_three++;
         if (dec_err_n === 1'b0) err_seen = 1'b1;
         quiet = (active === 1'b0) ? quiet + 1 : 0;
      end
      if (n >= 6000 || active !== 1'b0) begin
         mismatches++;
         complete_run();
      end
   endtask

   task automatic step_knob(input logic [3:0] digit, input logic ccw);
      @(posedge clk);
      res <= digit;
      fork
         u_panel.turn(ccw);
         wait_done();
      join
   endtask

   task automatic load_word(input logic [35:0] f);
      @(posedge clk);
      load <= 1'b1;
      load_freq <= f;
      @(posedge clk);
      load <= 1'b0;
      wait_done();
   endtask

   // Reset values, then a load that the guard must swallow
   task automatic sc_reset_guard();
      int n;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      load <= 1'b1;
      load_freq <= 36'h001000000;
      @(posedge clk);
      load <= 1'b0;
      @(negedge clk);
      check_flag(guard, 8'h01);
      check_freq(freq, PRESET_BCD);
      check_flag({band, range_err, dec_err_n}, 8'h01);
      n = 0;
      while (guard !== 1'b0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      check_flag(guard, 8'h00);
      repeat (80) @(negedge clk);
      check_freq(freq, PRESET_BCD);
   endtask

   // Single steps at 1 kHz, both directions, tick counts per cycle
   task automatic sc_one_khz();
      step_knob(4'h0, 1'b0);
      check_freq(freq, 36'h003000001);
      check_flag(knob_dir, 8'h00);
      check_flag(8'(n_two), 8'h09);
      check_flag(8'(n_three), 8'h09);
      step_knob(4'h0, 1'b1);
      check_freq(freq, PRESET_BCD);
      check_flag(knob_dir, 8'h01);
   endtask

   // Each digit from 10 kHz up to 1 GHz; band one never rounds
   task automatic sc_digits();
      for (int k = 1; k <= 6; k++) begin
         step_knob(k[3:0], 1'b0);
         check_freq(freq, PRESET_BCD + (36'h1 << (4 * k)));
         step_knob(k[3:0], 1'b1);
         check_freq(freq, PRESET_BCD);
      end
   endtask

   // Band edges and an out-of-range remote load
   task automatic sc_bands();
      load_word(36'h010000000);
      check_flag(band, 8'h01);
      load_word(36'h018000000);
      check_flag(band, 8'h02);
      load_word(36'h001000000);
      check_freq(freq, 36'h001000000);
      check_flag(range_err, 8'h01);
      load_word(36'h002000000);
      check_flag({band, range_err}, 8'h00);
   endtask

   // Limit undo, then the suppress strap lets it stand
   task automatic sc_limits();
      step_knob(4'h0, 1'b1);
      check_freq(freq, 36'h002000000);
      @(posedge clk);
      suppr_strap <= 1'b1;
      step_knob(4'h0, 1'b1);
      check_freq(freq, 36'h001999999);
      check_flag(range_err, 8'h01);
      @(posedge clk);
      suppr_strap <= 1'b0;
      fork
         u_panel.press_preset();
         wait_done();
      join
      check_freq(freq, 36'h003000000);
      check_flag(range_err, 8'h00);
   endtask

   // Odd kHz in band two must be rounded by one
   task automatic sc_round();
      load_word(36'h010000001);
      check_flag(err_seen, 8'h01);
      check_flag((freq === 36'h010000000) || (freq === 36'h010000002),
         8'h01);
      check_flag(dec_err_n, 8'h01);
   endtask

   // Forced cycles repeat with nothing to do; a low enable holds them off
   task automatic sc_force();
      logic prev;
      n_rise = 0;
      prev = 1'b0;
      @(posedge clk);
      ce <= 1'b0;
      force_strap <= 1'b1;
      repeat (20) @(negedge clk);
      check_flag(active, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      repeat (400) begin
         @(negedge clk);
         if (active === 1'b1 && prev === 1'b0) n_rise++;
         prev = active;
      end
      @(posedge clk);
      force_strap <= 1'b0;
      wait_done();
      check_flag(n_rise >= 3, 8'h01);
      check_freq(freq, PRESET_BCD);
   endtask

   initial begin
      sc_reset_guard();
      sc_one_khz();
      sc_digits();
      sc_bands();
      sc_limits();
      sc_round();
      fork
         u_panel.press_preset();
         wait_done();
      join
      sc_force();
      complete_run();
   end
endmodule // testbench
